//--- hdl/strap_regs.svh
`ifndef STRAP_REGS_SVH
`define STRAP_REGS_SVH

// System clock period in nanoseconds.
`define STRAP_CLK_PERIOD_NS 40

// A strap level must hold this long before it is believed.
`define STRAP_FILTER_TIME_NS 1000

// Least time, so the cycle count rounds up.
`define STRAP_FILTER_CYCLES ((`STRAP_FILTER_TIME_NS + `STRAP_CLK_PERIOD_NS - 1) / `STRAP_CLK_PERIOD_NS)

// Width of the settle counter; it must hold STRAP_FILTER_CYCLES - 1.
`define STRAP_CNT_W 5

// Value of every decoded output while reset is applied.
`define STRAP_OUT_RST 1'b0

`endif

//--- hdl/strap_pkg.sv
`include "strap_regs.svh"

package strap_pkg;

	// Three levels that a strap pin can present.
	typedef enum logic [2:0] {
		LVL_LOW = 3'b001,
		LVL_HIGH = 3'b010,
		LVL_FLOAT = 3'b100
	} level_type;

	// Sequencing of the decoder.
	typedef enum logic [2:0] {
		ST_WAIT = 3'b001,
		ST_SWITCH = 3'b010,
		ST_RUN = 3'b100
	} main_state_type;

	// State of one strap filter.
	typedef struct packed {
		logic hi1;
		logic lo1;
		logic hi2;
		logic lo2;
		level_type cand;
		logic [`STRAP_CNT_W-1:0] cnt;
		level_type stable;
		logic valid;
	} filter_state_type;

	// State of the decoder; every output is a field here.
	typedef struct packed {
		main_state_type st;
		logic ext;
		logic sp_en;
		logic sclk;
		logic sdin;
		logic ssel;
		logic rise;
		logic ddr;
		logic cal;
		logic des;
		logic range;
		logic swing;
		logic valid;
	} decode_state_type;

	// Comparator pair to level: above the upper threshold wins, neither means floating.
	function automatic level_type to_level(input logic hi, input logic lo);
		if (hi) begin
			return LVL_HIGH;
		end
		if (lo) begin
			return LVL_LOW;
		end
		return LVL_FLOAT;
	endfunction

	// True when a strap is left open.
	function automatic logic is_float(input level_type lvl);
		return lvl == LVL_FLOAT;
	endfunction

endpackage

//--- hdl/strap_level_if.sv
`timescale 1ns/1ns

interface strap_level_if;
	strap_pkg::level_type level;
	logic valid;
	logic bit_level;

	modport src (
		output level,
		output valid,
		output bit_level
	);

	modport dst (
		input level,
		input valid,
		input bit_level
	);
endinterface

//--- hdl/strap_filter.sv
`timescale 1ns/1ns
`include "strap_regs.svh"

module strap_filter (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Comparator outputs of one tri-level pin.
	input wire logic pin_hi,
	input wire logic pin_lo,
	// Filtered level toward the decoder.
	strap_level_if.src lvl
);

	strap_pkg::filter_state_type s_r;
	strap_pkg::filter_state_type s_nxt;
	strap_pkg::level_type cur_level;

	// Level seen after the second synchroniser stage only.
	assign cur_level = strap_pkg::to_level(s_r.hi2, s_r.lo2);

	// Two-stage synchroniser then a settle counter; a pin in transit crosses the middle band and would
	// look floating for a moment, so a level is only believed after it has held steady.
	always_comb begin
		s_nxt = s_r;
		s_nxt.hi1 = pin_hi;
		s_nxt.lo1 = pin_lo;
		s_nxt.hi2 = s_r.hi1;
		s_nxt.lo2 = s_r.lo1;
		if (cur_level != s_r.cand) begin
			s_nxt.cand = cur_level;
			s_nxt.cnt = '0;
		end else if (s_r.cnt != `STRAP_CNT_W'(`STRAP_FILTER_CYCLES - 1)) begin
			s_nxt.cnt = s_r.cnt + `STRAP_CNT_W'(1);
		end else begin
			s_nxt.stable = s_r.cand;
			s_nxt.valid = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '{hi1: 1'b0, lo1: 1'b0, hi2: 1'b0, lo2: 1'b0, cand: strap_pkg::LVL_FLOAT,
				cnt: '0, stable: strap_pkg::LVL_FLOAT, valid: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// The raw digital level serves the serial functions, which must not see the settle delay.
	assign lvl.level = s_r.stable;
	assign lvl.valid = s_r.valid;
	assign lvl.bit_level = s_r.hi2;

endmodule

//--- hdl/strap_mode_decoder.sv
`timescale 1ns/1ns
`include "strap_regs.svh"

module strap_mode_decoder (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Mode strap comparators.
	input wire logic mode_strap_hi,
	input wire logic mode_strap_lo,
	// Output swing strap comparators, serial clock in extended mode.
	input wire logic swing_strap_hi,
	input wire logic swing_strap_lo,
	// Launch edge strap comparators, serial data in extended mode.
	input wire logic edge_strap_hi,
	input wire logic edge_strap_lo,
	// Calibration strap comparators, serial select in extended mode.
	input wire logic cal_strap_hi,
	input wire logic cal_strap_lo,
	// Mode and serial port.
	output logic extended_mode,
	output logic serial_port_enable,
	output logic serial_clock,
	output logic serial_port_input,
	output logic serial_port_select,
	// Pin-controlled settings.
	output logic launch_edge_select,
	output logic ddr_enable,
	output logic cal_delay_high,
	output logic dual_edge_sampling,
	output logic input_range_high,
	output logic output_swing_high,
	// Settings have been decoded at least once.
	output logic settings_valid
);

	////////////////////////////////////////////////////////////////////////////////

	strap_level_if mode_lvl ();
	strap_level_if swing_lvl ();
	strap_level_if edge_lvl ();
	strap_level_if cal_lvl ();

	// One filter per tri-level pin; each one synchronises before anything decodes.
	strap_filter mode_filter (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_hi(mode_strap_hi),
		.pin_lo(mode_strap_lo),
		.lvl(mode_lvl)
	);

	strap_filter swing_filter (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_hi(swing_strap_hi),
		.pin_lo(swing_strap_lo),
		.lvl(swing_lvl)
	);

	strap_filter edge_filter (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_hi(edge_strap_hi),
		.pin_lo(edge_strap_lo),
		.lvl(edge_lvl)
	);

	strap_filter cal_filter (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin_hi(cal_strap_hi),
		.pin_lo(cal_strap_lo),
		.lvl(cal_lvl)
	);

	////////////////////////////////////////////////////////////////////////////////

	strap_pkg::decode_state_type s_r;
	strap_pkg::decode_state_type s_nxt;
	logic all_valid;
	logic want_ext;

	// Nothing is decoded until every pin has first settled; after that each pin is decoded as soon as its own filter settles.
	assign all_valid = mode_lvl.valid & swing_lvl.valid & edge_lvl.valid & cal_lvl.valid;

	// Open mode strap means extended control.
	assign want_ext = strap_pkg::is_float(mode_lvl.level);

	// Next-state and decode logic. A mode change passes through one cycle with all outputs but ext and valid off, so the
	// serial port and the pin functions are never active together on a shared pin.
	always_comb begin
		s_nxt = s_r;
		case (s_r.st)
			strap_pkg::ST_WAIT: begin
				if (all_valid) begin
					s_nxt.st = strap_pkg::ST_RUN;
					s_nxt.ext = want_ext;
				end
			end
			strap_pkg::ST_SWITCH: begin
				s_nxt.st = strap_pkg::ST_RUN;
				s_nxt.ext = want_ext;
			end
			strap_pkg::ST_RUN: begin
				if (want_ext != s_r.ext) begin
					s_nxt.st = strap_pkg::ST_SWITCH;
				end
			end
			default: begin
				s_nxt.st = strap_pkg::ST_WAIT;
			end
		endcase

		// All outputs but ext and valid start from off and are then filled for the mode in force.
		s_nxt.sp_en = `STRAP_OUT_RST;
		s_nxt.sclk = `STRAP_OUT_RST;
		s_nxt.sdin = `STRAP_OUT_RST;
		s_nxt.ssel = `STRAP_OUT_RST;
		s_nxt.rise = `STRAP_OUT_RST;
		s_nxt.ddr = `STRAP_OUT_RST;
		s_nxt.cal = `STRAP_OUT_RST;
		s_nxt.des = `STRAP_OUT_RST;
		s_nxt.range = `STRAP_OUT_RST;
		s_nxt.swing = `STRAP_OUT_RST;
		s_nxt.valid = s_r.valid;

		if (s_nxt.st == strap_pkg::ST_RUN) begin
			s_nxt.valid = 1'b1;
			if (s_nxt.ext) begin
				// Shared pins become the serial port; pin functions stay off.
				s_nxt.sp_en = 1'b1;
				s_nxt.sclk = swing_lvl.bit_level;
				s_nxt.sdin = edge_lvl.bit_level;
				s_nxt.ssel = cal_lvl.bit_level;
			end else begin
				// Serial port held idle; settings come from the strap levels alone. A mode strap that
				// drifts open here would flip the block into extended mode, hence the board must hold it.
				s_nxt.sp_en = 1'b0;
				s_nxt.range = (mode_lvl.level == strap_pkg::LVL_HIGH);
				s_nxt.swing = (swing_lvl.level == strap_pkg::LVL_HIGH);
				s_nxt.ddr = strap_pkg::is_float(edge_lvl.level);
				s_nxt.rise = (edge_lvl.level == strap_pkg::LVL_HIGH);
				s_nxt.cal = (cal_lvl.level == strap_pkg::LVL_HIGH);
				s_nxt.des = strap_pkg::is_float(cal_lvl.level);
			end
		end
	end

	// State register; every output field resets to off.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_r <= '{st: strap_pkg::ST_WAIT, ext: `STRAP_OUT_RST, sp_en: `STRAP_OUT_RST,
				sclk: `STRAP_OUT_RST, sdin: `STRAP_OUT_RST, ssel: `STRAP_OUT_RST,
				rise: `STRAP_OUT_RST, ddr: `STRAP_OUT_RST, cal: `STRAP_OUT_RST,
				des: `STRAP_OUT_RST, range: `STRAP_OUT_RST, swing: `STRAP_OUT_RST,
				valid: `STRAP_OUT_RST};
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Outputs straight from the state register.
	assign extended_mode = s_r.ext;
	assign serial_port_enable = s_r.sp_en;
	assign serial_clock = s_r.sclk;
	assign serial_port_input = s_r.sdin;
	assign serial_port_select = s_r.ssel;
	assign launch_edge_select = s_r.rise; // High means launch on the rising strobe edge.
	assign ddr_enable = s_r.ddr;
	assign cal_delay_high = s_r.cal;
	assign dual_edge_sampling = s_r.des;
	assign input_range_high = s_r.range;
	assign output_swing_high = s_r.swing;
	assign settings_valid = s_r.valid;

endmodule

//--- verification/strap_mode_checker.sv
`timescale 1ns/1ns

// Watches the decoder ports only; everything runs on one clock.
module strap_mode_checker (
	// Clock and reset.
	input wire logic clk,
	input wire logic sys_rst,
	// Strap comparators.
	input wire logic mode_strap_hi,
	input wire logic mode_strap_lo,
	input wire logic swing_strap_hi,
	input wire logic swing_strap_lo,
	input wire logic edge_strap_hi,
	input wire logic edge_strap_lo,
	input wire logic cal_strap_hi,
	input wire logic cal_strap_lo,
	// Decoded outputs.
	input wire logic extended_mode,
	input wire logic serial_port_enable,
	input wire logic serial_clock,
	input wire logic serial_port_input,
	input wire logic serial_port_select,
	input wire logic launch_edge_select,
	input wire logic ddr_enable,
	input wire logic cal_delay_high,
	input wire logic dual_edge_sampling,
	input wire logic input_range_high,
	input wire logic output_swing_high,
	input wire logic settings_valid
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////
	// Leaving extended mode drops the port one cycle before the mode flag.
	sequence s_leave_ext;
		extended_mode ##1 !extended_mode;
	endsequence

	// Depth 6 keeps the sampled pin well inside the settle window.
	a_serial_off: assert property (!extended_mode |->
		!(serial_port_enable || serial_clock || serial_port_input || serial_port_select))
		else $error("serial port active in pin mode");
	a_ext_pins_zero: assert property (extended_mode |->
		!(launch_edge_select || ddr_enable || cal_delay_high || dual_edge_sampling ||
		input_range_high || output_swing_high))
		else $error("pin settings active in extended mode");
	a_ddr_no_edge: assert property (ddr_enable |-> !launch_edge_select)
		else $error("edge select set with double rate");
	a_des_low_delay: assert property (dual_edge_sampling |-> !cal_delay_high)
		else $error("dual edge with high delay");
	a_mode_open: assert property ($rose(extended_mode) |-> $past(!mode_strap_hi && !mode_strap_lo, 6))
		else $error("extended mode without open mode pin");
	a_mode_driven: assert property ($fell(extended_mode) |-> $past(mode_strap_hi || mode_strap_lo, 6))
		else $error("pin mode without driven mode pin");
	a_serial_follow: assert property (serial_port_enable |->
		serial_clock == $past(swing_strap_hi, 3) && serial_port_input == $past(edge_strap_hi, 3) &&
		serial_port_select == $past(cal_strap_hi, 3))
		else $error("serial pass-through wrong");
	a_switch_order: assert property ($fell(serial_port_enable) |-> s_leave_ext)
		else $error("mode switch out of order");
	a_valid_sticky: assert property (settings_valid |=> settings_valid)
		else $error("valid flag dropped");
	a_quiet_unset: assert property (!settings_valid |->
		!(extended_mode || ddr_enable || input_range_high || output_swing_high))
		else $error("outputs before settle");
endmodule

//--- verification/strap_board_model.sv
`timescale 1ns/1ns

// Board straps: each pin is tied low, tied high or left open.
module strap_board_model (
	// Two bits a pin: 0 low, 1 high, 2 or 3 open.
	input wire logic [7:0] lvl,
	// Comparator view of the four pins.
	output logic [3:0] hi,
	output logic [3:0] lo
);
	// An open pin crosses neither threshold; the mode pin is open only on purpose.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			hi[i] = lvl[2*i +: 2] == 2'h1;
			lo[i] = lvl[2*i +: 2] == 2'h0;
		end
	end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ns

module tb_top;
	logic clk;
	logic sys_rst;
	logic [7:0] lvl_r;
	logic [3:0] hi;
	logic [3:0] lo;
	logic [11:0] obs;
	int fail_count;
	int n_compared;

	// Clock at 25 MHz.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	strap_board_model strap_board_model_inst (.lvl(lvl_r), .hi(hi), .lo(lo));

	strap_mode_decoder strap_mode_decoder_inst (
		.clk(clk), .sys_rst(sys_rst), .mode_strap_hi(hi[3]), .mode_strap_lo(lo[3]),
		.swing_strap_hi(hi[2]), .swing_strap_lo(lo[2]), .edge_strap_hi(hi[1]), .edge_strap_lo(lo[1]),
		.cal_strap_hi(hi[0]), .cal_strap_lo(lo[0]), .extended_mode(obs[11]), .serial_port_enable(obs[10]),
		.serial_clock(obs[9]), .serial_port_input(obs[8]), .serial_port_select(obs[7]),
		.launch_edge_select(obs[6]), .ddr_enable(obs[5]), .cal_delay_high(obs[4]),
		.dual_edge_sampling(obs[3]), .input_range_high(obs[2]), .output_swing_high(obs[1]),
		.settings_valid(obs[0])
	);

	////////////////////////////////////////////////////////////////////////
	// Expected outputs from levels 0 low, 1 high, 2 open.
	function automatic logic [11:0] model(input int m, input int s, input int e, input int c);
		if (m == 2) begin
			return {2'h3, s == 1, e == 1, c == 1, 6'h00, 1'b1};
		end
		return {5'h00, e == 1, e == 2, c == 1, c == 2, m == 1, s == 1, 1'b1};
	endfunction

	task automatic check(input logic [11:0] exp);
		n_compared++;
		if (obs !== exp) begin
			fail_count++;
			$display("mismatch at %0t: outputs %h, expected %h", $time, obs, exp);
		end
	endtask

	// Fixed wait: the settle time is a fixed count, so no handshake exists.
	task automatic settle(input int m, input int s, input int e, input int c);
		@(posedge clk);
		lvl_r <= {m[1:0], s[1:0], e[1:0], c[1:0]};
		repeat (40) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		int m, s, e, c, n, p;
		logic [11:0] keep;
		void'($urandom(86));
		fail_count = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		lvl_r = 8'h00;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		// Every mix of levels; the step from mode level 1 to 2 exercises the switch into extended mode.
		for (m = 0; m < 3; m++) begin
			for (s = 0; s < 3; s++) begin
				for (e = 0; e < 3; e++) begin
					for (c = 0; c < 3; c++) begin
						settle(m, s, e, c);
						check(model(m, s, e, c));
					end
				end
			end
		end
		// Pulses shorter than the filter time must leave the settings alone.
		for (n = 0; n < 12; n++) begin
			settle($urandom % 2, $urandom % 3, $urandom % 3, $urandom % 3);
			keep = obs;
			p = 2 * ($urandom % 4);
			@(posedge clk);
			lvl_r <= lvl_r ^ (8'h02 << p);
			repeat (1 + $urandom % 20) @(posedge clk);
			lvl_r <= lvl_r ^ (8'h02 << p);
			repeat (5) @(posedge clk);
			@(negedge clk);
			check(keep);
		end
		// Serial traffic in extended mode passes straight through.
		settle(2, 0, 0, 0);
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			lvl_r[5:0] <= 6'($urandom) & 6'h15;
		end
		settle(2, 1, 0, 1);
		check(model(2, 1, 0, 1));
		// A second reset in mid-run clears everything.
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		check(12'h000);
		// The first edge out of reset must still show nothing, since no filter has settled yet.
		@(negedge clk);
		check(12'h000);
		settle(1, 0, 1, 0);
		check(model(1, 0, 1, 0));
		final_report();
	end
endmodule

bind strap_mode_decoder strap_mode_checker strap_mode_checker_inst (
	.clk, .sys_rst, .mode_strap_hi, .mode_strap_lo, .swing_strap_hi, .swing_strap_lo,
	.edge_strap_hi, .edge_strap_lo, .cal_strap_hi, .cal_strap_lo, .extended_mode,
	.serial_port_enable, .serial_clock, .serial_port_input, .serial_port_select,
	.launch_edge_select, .ddr_enable, .cal_delay_high, .dual_edge_sampling,
	.input_range_high, .output_swing_high, .settings_valid
);
